/* File: verilog/arfc_codec.v */
`timescale 1ns/1ns
`include "arfc_defs.vh"
// What this block does
// (R01) IPv4 destination sits right-aligned in low 32 bits, upper bytes zero.
// (R02) Low six address bytes are a MAC only when equal to own MAC.
// (R03) Remote option bit 0x02 applies changes; else apply later.
// (R04) Remote command name at offsets 14 and 15, first char in high byte.
// (R05) Parameter bytes present means set; none present means query.
// (R06) Local frame 0x08: name at 5-6, parameter 7-n, apply at once.
// (R07) Local frame with checksum right after name is a query.
// (R08) Transmit 0x10 with nonzero ID yields status 0x8B; zero gives none.
// (R09) Transmit option 0x01 disables ack; bytes 13-15 unused.
// (R10) Transmit payload from offset 17, at most 1392 bytes, rest dropped.
// (R11) Checksum is 0xFF minus low byte of sum from type byte.
// (R12) Length counts frame data bytes only.
// (R13) Nonzero frame ID returned in response; zero suppresses it.
// (R14) Frame: delimiter 0x7E, length MSB first, type, then ID.
// (R15) Remote command request is frame type 0x07 at fixed offsets.
module arfc_codec #(
    parameter MAX_PAYLOAD = 1392
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Serial byte stream from the host, already deserialised
    input wire [7:0] i_rx_byte,
    input wire i_rx_valid,
    // Own identity
    input wire [47:0] i_own_mac,
    // Decoded command
    output reg o_cmd_valid,
    output reg o_cmd_remote,
    output reg o_cmd_set,
    output reg o_cmd_apply,
    output reg [15:0] o_cmd_name,
    output reg [7:0] o_frame_id,
    output reg o_resp_req,
    output reg [63:0] o_dest_addr,
    output reg o_dest_is_mac,
    // Parameter and payload bytes
    output reg [7:0] o_data_byte,
    output reg o_data_valid,
    // Transmit request
    output reg o_tx_valid,
    output reg o_tx_noack,
    output reg [15:0] o_tx_len,
    output reg o_tx_truncated,
    output reg [7:0] o_status_type,
    // Errors
    output reg o_frame_error
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam S_IDLE = 3'd0;
    localparam S_LEN_HI = 3'd1;
    localparam S_LEN_LO = 3'd2;
    localparam S_BODY = 3'd3;
    localparam S_CKSUM = 3'd4;

    // ------------------------------------------------------------
    // Byte capture
    // ------------------------------------------------------------
    // Strobe and byte cross as one word. The byte is taken one clock
    // after the strobe is first seen high, so a data bit that settled a
    // clock later than the strobe is already valid.
    wire [8:0] sync_w;
    reg [1:0] strobe_q;
    wire take_w;
    wire [7:0] byte_w;

    // Bit eight carries the strobe, the bits below it the byte.
    arfc_sync #(.W(9)) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({i_rx_valid, i_rx_byte}),
        .o_q(sync_w)
    );

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            strobe_q <= 2'h0;
        else
            strobe_q <= {strobe_q[0], sync_w[8]};
    end

    assign take_w = strobe_q[0] && !strobe_q[1];
    assign byte_w = sync_w[7:0];

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    reg [2:0] state_q;
    reg [15:0] len_q;
    reg [15:0] ofs_q;
    reg [7:0] sum_q;
    reg [7:0] type_q;
    reg [7:0] id_q;
    reg [7:0] opt_q;
    reg [15:0] name_q;
    reg [63:0] addr_q;
    reg [15:0] pay_q;
    reg trunc_q;

    // ------------------------------------------------------------
    // Field helpers
    // ------------------------------------------------------------
    localparam [15:0] PAY_LIMIT = MAX_PAYLOAD[15:0];
    wire [15:0] hdr_w;
    wire known_w;
    wire [15:0] body_end_w;
    wire cksum_ok_w;
    wire len_ok_w;
    wire good_w;

    assign known_w = (type_q == `ARFC_TYPE_REMOTE) || // R15
        (type_q == `ARFC_TYPE_LOCAL) || (type_q == `ARFC_TYPE_TX);
    // Fixed bytes from the type byte up to the first data byte.
    assign hdr_w = (type_q == `ARFC_TYPE_REMOTE) ? `ARFC_HDR_REMOTE :
        (type_q == `ARFC_TYPE_LOCAL) ? `ARFC_HDR_LOCAL : `ARFC_HDR_TX;
    // Offset of the last frame data byte: 2 + length.
    assign body_end_w = len_q + 16'h0002; // R12
    // With the checksum added, the low byte of the sum is 0xFF.
    assign cksum_ok_w = (byte_w == `ARFC_CKSUM_BASE - sum_q); // R11
    // A frame shorter than its fixed fields cannot be decoded.
    assign len_ok_w = (len_q >= hdr_w);
    assign good_w = cksum_ok_w && known_w && len_ok_w;

    // ------------------------------------------------------------
    // Parser
    // ------------------------------------------------------------
    // A frame cut short leaves the parser waiting for body bytes, and the
    // next delimiter is then read as data; the host must finish each
    // frame it starts.
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= S_IDLE;
            len_q <= 16'h0000;
            ofs_q <= 16'h0000;
            sum_q <= 8'h00;
            type_q <= 8'h00;
            id_q <= 8'h00;
            opt_q <= 8'h00;
            name_q <= 16'h0000;
            addr_q <= 64'h0000_0000_0000_0000;
            pay_q <= 16'h0000;
            trunc_q <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_cmd_remote <= 1'b0;
            o_cmd_set <= 1'b0;
            o_cmd_apply <= 1'b0;
            o_cmd_name <= 16'h0000;
            o_frame_id <= 8'h00;
            o_resp_req <= 1'b0;
            o_dest_addr <= 64'h0000_0000_0000_0000;
            o_dest_is_mac <= 1'b0;
            o_data_byte <= 8'h00;
            o_data_valid <= 1'b0;
            o_tx_valid <= 1'b0;
            o_tx_noack <= 1'b0;
            o_tx_len <= 16'h0000;
            o_tx_truncated <= 1'b0;
            o_status_type <= 8'h00;
            o_frame_error <= 1'b0;
        end
        else
        begin
            o_cmd_valid <= 1'b0;
            o_tx_valid <= 1'b0;
            o_data_valid <= 1'b0;
            o_frame_error <= 1'b0;
            if (take_w)
            begin
                case (state_q)
                    S_IDLE:
                    begin
                        if (byte_w == `ARFC_DELIM) // R14
                            state_q <= S_LEN_HI;
                    end
                    S_LEN_HI:
                    begin
                        len_q <= {byte_w, 8'h00}; // R14
                        state_q <= S_LEN_LO;
                    end
                    S_LEN_LO:
                    begin
                        len_q <= {len_q[15:8], byte_w};
                        // Fields of the new frame restart here.
                        ofs_q <= `ARFC_OFS_TYPE;
                        sum_q <= 8'h00;
                        pay_q <= 16'h0000;
                        trunc_q <= 1'b0;
                        opt_q <= 8'h00;
                        addr_q <= 64'h0000_0000_0000_0000;
                        if ({len_q[15:8], byte_w} == 16'h0000)
                            state_q <= S_CKSUM;
                        else
                            state_q <= S_BODY;
                    end
                    S_BODY:
                    begin
                        // Offsets count from the delimiter at zero.
                        sum_q <= sum_q + byte_w; // R11
                        ofs_q <= ofs_q + 16'h0001;
                        if (ofs_q == `ARFC_OFS_TYPE)
                            type_q <= byte_w;
                        else if (ofs_q == `ARFC_OFS_ID)
                            id_q <= byte_w;
                        else if (type_q == `ARFC_TYPE_LOCAL)
                        begin
                            if (ofs_q == `ARFC_OFS_LCMD0) // R06
                                name_q[15:8] <= byte_w;
                            else if (ofs_q == `ARFC_OFS_LCMD1)
                                name_q[7:0] <= byte_w;
                            else
                            begin
                                o_data_byte <= byte_w; // R05
                                o_data_valid <= 1'b1;
                                pay_q <= pay_q + 16'h0001;
                            end
                        end
                        else if (type_q == `ARFC_TYPE_REMOTE ||
                            type_q == `ARFC_TYPE_TX)
                        begin
                            if (ofs_q <= `ARFC_OFS_ADDR_LAST)
                                addr_q <= {addr_q[55:0], byte_w}; // R01
                            else if (type_q == `ARFC_TYPE_REMOTE)
                            begin
                                if (ofs_q == `ARFC_OFS_ROPT)
                                    opt_q <= byte_w; // R03
                                else if (ofs_q == `ARFC_OFS_RCMD0)
                                    name_q[15:8] <= byte_w; // R04
                                else if (ofs_q == `ARFC_OFS_RCMD1)
                                    name_q[7:0] <= byte_w; // R04
                                else
                                begin
                                    o_data_byte <= byte_w; // R05
                                    o_data_valid <= 1'b1;
                                    pay_q <= pay_q + 16'h0001;
                                end
                            end
                            else if (ofs_q == `ARFC_OFS_TXOPT)
                                opt_q <= byte_w; // R09
                            else if (ofs_q >= `ARFC_OFS_TXDATA)
                            begin
                                // Excess bytes still enter the checksum.
                                if (pay_q < PAY_LIMIT) // R10
                                begin
                                    o_data_byte <= byte_w;
                                    o_data_valid <= 1'b1;
                                    pay_q <= pay_q + 16'h0001;
                                end
                                else
                                    trunc_q <= 1'b1; // R10
                            end
                        end
                        if (ofs_q == body_end_w)
                            state_q <= S_CKSUM;
                    end
                    S_CKSUM:
                    begin
                        state_q <= S_IDLE;
                        if (!good_w) // R11
                            o_frame_error <= 1'b1;
                        else
                        begin
                            o_frame_id <= id_q;
                            o_resp_req <= (id_q != 8'h00); // R13
                            o_dest_addr <= addr_q;
                            // Only the low six bytes are compared.
                            o_dest_is_mac <= (type_q != `ARFC_TYPE_LOCAL)
                                && (addr_q[47:0] == i_own_mac); // R02
                            if (type_q == `ARFC_TYPE_TX)
                            begin
                                o_tx_valid <= 1'b1; // R08
                                o_tx_noack <= opt_q[`ARFC_BIT_NOACK]; // R09
                                o_tx_len <= pay_q;
                                o_tx_truncated <= trunc_q;
                                o_status_type <= (id_q != 8'h00) ?
                                    `ARFC_TYPE_TX_STATUS : 8'h00; // R08
                            end
                            else
                            begin
                                o_cmd_valid <= 1'b1;
                                o_cmd_name <= name_q;
                                o_cmd_remote <= (type_q == `ARFC_TYPE_REMOTE);
                                // No bytes after the name means a query.
                                o_cmd_set <= (pay_q != 16'h0000); // R05 R07
                                o_cmd_apply <=
                                    (type_q == `ARFC_TYPE_LOCAL) || // R06
                                    opt_q[`ARFC_BIT_APPLY]; // R03
                                o_status_type <= 8'h00;
                            end
                        end
                    end
                    default:
                        state_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule // arfc_codec

/* File: verilog/arfc_defs.vh */
`ifndef ARFC_DEFS_VH
`define ARFC_DEFS_VH
// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define ARFC_DELIM 8'h7E
`define ARFC_TYPE_REMOTE 8'h07
`define ARFC_TYPE_LOCAL 8'h08
`define ARFC_TYPE_TX 8'h10
`define ARFC_TYPE_TX_STATUS 8'h8B
`define ARFC_CKSUM_BASE 8'hFF
`define ARFC_OFS_TYPE 16'h0003
`define ARFC_OFS_ID 16'h0004
`define ARFC_OFS_ADDR_FIRST 16'h0005
`define ARFC_OFS_ADDR_LAST 16'h000C
`define ARFC_OFS_MAC_FIRST 16'h0007
`define ARFC_OFS_IP_FIRST 16'h0009
`define ARFC_OFS_ROPT 16'h000D
`define ARFC_OFS_RCMD0 16'h000E
`define ARFC_OFS_RCMD1 16'h000F
`define ARFC_OFS_LCMD0 16'h0005
`define ARFC_OFS_LCMD1 16'h0006
`define ARFC_OFS_TXOPT 16'h0010
`define ARFC_OFS_TXDATA 16'h0011
`define ARFC_BIT_APPLY 1
`define ARFC_BIT_NOACK 0
`define ARFC_MAX_PAYLOAD 16'h0570
// Fixed bytes ahead of the parameter or payload, counted from type.
`define ARFC_HDR_REMOTE 16'h000D
`define ARFC_HDR_LOCAL 16'h0004
`define ARFC_HDR_TX 16'h000E
`endif

/* File: verilog/arfc_sync.v */
`timescale 1ns/1ns
`include "arfc_defs.vh"
// Three-stage synchroniser; output changes when stages two and three agree.
module arfc_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Data
    input wire [W-1:0] i_d,
    output reg [W-1:0] o_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    genvar g;
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            always @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    o_q[g] <= 1'b0;
                else if (s2_q[g] == s3_q[g])
                    o_q[g] <= s3_q[g];
            end
        end
    endgenerate
endmodule // arfc_sync

/* File: testbench/arfc_props.sv */
`timescale 1ns/1ns
module arfc_props #(
    parameter MAX_PAYLOAD = 1392
) (
    // Clock, reset and identity
    input wire i_clk,
    input wire i_nrst,
    input wire [47:0] i_own_mac,
    // Codec outputs
    input wire o_cmd_valid,
    input wire o_cmd_remote,
    input wire o_cmd_apply,
    input wire [7:0] o_frame_id,
    input wire o_resp_req,
    input wire [63:0] o_dest_addr,
    input wire o_dest_is_mac,
    input wire o_data_valid,
    input wire o_tx_valid,
    input wire [15:0] o_tx_len,
    input wire o_tx_truncated,
    input wire [7:0] o_status_type,
    input wire o_frame_error
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    property p_lapply;
        o_cmd_valid && !o_cmd_remote |-> o_cmd_apply;
    endproperty
    a_lapply: assert property (p_lapply) else $error("local no apply");
    property p_resp;
        o_cmd_valid |-> o_resp_req == (o_frame_id != 8'h00);
    endproperty
    a_resp: assert property (p_resp) else $error("bad resp flag");
    property p_stat;
        o_tx_valid |-> o_status_type == ((o_frame_id != 8'h00) ? 8'h8B : 8'h00);
    endproperty
    a_stat: assert property (p_stat) else $error("bad status type");
    property p_rej;
        o_frame_error |-> !o_cmd_valid && !o_tx_valid;
    endproperty
    a_rej: assert property (p_rej) else $error("bad frame accepted");
    property p_mac;
        o_cmd_valid && o_cmd_remote |->
            o_dest_is_mac == (o_dest_addr[47:0] == i_own_mac);
    endproperty
    a_mac: assert property (p_mac) else $error("bad mac match");
    property p_len;
        o_tx_valid |-> o_tx_len <= MAX_PAYLOAD;
    endproperty
    a_len: assert property (p_len) else $error("payload too long");
    property p_trunc;
        o_tx_valid && o_tx_truncated |-> o_tx_len == MAX_PAYLOAD;
    endproperty
    a_trunc: assert property (p_trunc) else $error("bad cut length");
    property p_gap;
        o_data_valid |=> !o_data_valid [*7];
    endproperty
    a_gap: assert property (p_gap) else $error("extra data byte");
    c_remote: cover property (o_cmd_valid && o_cmd_remote);
    c_trunc: cover property (o_tx_valid && o_tx_truncated);
    c_err: cover property (o_frame_error);
endmodule // arfc_props

bind arfc_codec arfc_props #(.MAX_PAYLOAD(MAX_PAYLOAD)) u_props (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_own_mac(i_own_mac),
    .o_cmd_valid(o_cmd_valid), .o_cmd_remote(o_cmd_remote),
    .o_cmd_apply(o_cmd_apply), .o_frame_id(o_frame_id),
    .o_resp_req(o_resp_req), .o_dest_addr(o_dest_addr),
    .o_dest_is_mac(o_dest_is_mac), .o_data_valid(o_data_valid),
    .o_tx_valid(o_tx_valid), .o_tx_len(o_tx_len),
    .o_tx_truncated(o_tx_truncated), .o_status_type(o_status_type),
    .o_frame_error(o_frame_error));

/* File: testbench/arfc_host.sv */
`timescale 1ns/1ns
module arfc_host (
    // Clock
    input wire i_clk,
    // Byte stream to the codec
    output logic [7:0] o_byte,
    output logic o_valid
);
    initial o_byte = 8'h00;
    initial o_valid = 1'b0;
    // Strobe and byte stand together; once released the line shows the
    // inverse so a stale byte can never be mistaken for a fresh one.
    task automatic put(input logic [7:0] b);
        @(posedge i_clk);
        o_byte <= b;
        o_valid <= 1'b1;
        repeat (5) @(posedge i_clk);
        o_byte <= ~b;
        o_valid <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask
    // Sends one frame; bad flips the checksum's low bit.
    task automatic send(input logic [7:0] d[$], input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        put(8'h7E);
        put(8'(d.size() >> 8));
        put(8'(d.size()));
        foreach (d[i])
        begin
            put(d[i]);
            sum = sum + d[i];
        end
        put((8'hFF - sum) ^ {7'h00, bad});
    endtask
endmodule // arfc_host

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    localparam MAXP = 4;
    logic i_clk;
    logic i_nrst;
    wire [7:0] rx_byte;
    wire rx_valid;
    int mismatches, checked, ncmd, ntx, nerr, cyc;
    logic [7:0] fr[$];
    logic [7:0] dq[$];
    arfc_host host (.i_clk(i_clk), .o_byte(rx_byte), .o_valid(rx_valid));
    arfc_codec #(.MAX_PAYLOAD(MAXP)) dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_rx_byte(rx_byte),
        .i_rx_valid(rx_valid), .i_own_mac(48'h0A0B_0C0D_0E0F),
        .o_cmd_valid(), .o_cmd_remote(), .o_cmd_set(), .o_cmd_apply(),
        .o_cmd_name(), .o_frame_id(), .o_resp_req(), .o_dest_addr(),
        .o_dest_is_mac(), .o_data_byte(), .o_data_valid(), .o_tx_valid(),
        .o_tx_noack(), .o_tx_len(), .o_tx_truncated(), .o_status_type(),
        .o_frame_error());
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 6000) final_report(1'b1);
        if (dut.o_cmd_valid === 1'b1) ncmd++;
        if (dut.o_tx_valid === 1'b1) ntx++;
        if (dut.o_frame_error === 1'b1) nerr++;
        if (dut.o_data_valid === 1'b1) dq.push_back(dut.o_data_byte);
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report(input logic hung);
        if (hung) mismatches++;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic go(input logic bad);
        ncmd = 0;
        ntx = 0;
        nerr = 0;
        dq.delete();
        host.send(fr, bad);
    endtask
    task automatic t_rquery;
        fr = '{8'h07, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8,
            8'h00, 8'h64, 8'h02, 8'h44, 8'h4C};
        go(1'b0);
        check(ncmd, 1);
        check(dut.o_cmd_remote, 1'b1);
        check(dut.o_cmd_set, 1'b0);
        check(dut.o_cmd_apply, 1'b1);
        check(dut.o_cmd_name, 16'h444C);
        check(dut.o_frame_id, 8'h01);
        check(dut.o_resp_req, 1'b1);
        check(dq.size(), 0);
        check(dut.o_dest_addr, 64'h0000_0000_C0A8_0064);
        check(dut.o_dest_is_mac, 1'b0);
    endtask
    task automatic t_bad;
        go(1'b1);
        check(nerr, 1);
        check(ncmd, 0);
        check(ntx, 0);
        fr = '{8'h22, 8'h01};
        go(1'b0);
        check(nerr, 1);
        check(ncmd, 0);
    endtask
    task automatic t_rset;
        fr = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
            8'h0E, 8'h0F, 8'h00, 8'h44, 8'h31, 8'h03};
        go(1'b0);
        check(dut.o_cmd_set, 1'b1);
        check(dut.o_cmd_apply, 1'b0);
        check(dut.o_dest_is_mac, 1'b1);
        check(dut.o_resp_req, 1'b0);
        check(dq[0], 8'h03);
        check(dq.size(), 1);
    endtask
    task automatic t_local;
        fr = '{8'h08, 8'h02, 8'h4E, 8'h49};
        go(1'b0);
        check(dut.o_cmd_remote, 1'b0);
        check(dut.o_cmd_set, 1'b0);
        check(dq.size(), 0);
        check(dut.o_cmd_apply, 1'b1);
        check(dut.o_cmd_name, 16'h4E49);
        fr = '{8'h08, 8'h01, 8'h4E, 8'h49, 8'h41, 8'h42};
        go(1'b0);
        check(dut.o_cmd_set, 1'b1);
        check(dq.size(), 2);
        check(dq[1], 8'h42);
    endtask
    task automatic t_tx;
        fr = '{8'h10, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8,
            8'h01, 8'h82, 8'h00, 8'h00, 8'h00, 8'h01, 8'h48, 8'h65,
            8'h6C, 8'h6C, 8'h6F, 8'h21};
        go(1'b0);
        check(ntx, 1);
        check(dut.o_tx_noack, 1'b1);
        check(dut.o_tx_len, MAXP);
        check(dut.o_tx_truncated, 1'b1);
        check(dut.o_status_type, 8'h8B);
        check(dq.size(), MAXP);
        fr = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'hA8,
            8'h01, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h48, 8'h65};
        go(1'b0);
        check(dut.o_status_type, 8'h00);
        check(dut.o_tx_noack, 1'b0);
        check(dut.o_tx_len, 16'h0002);
        check(dut.o_tx_truncated, 1'b0);
    endtask
    initial
    begin
        i_nrst = 1'b0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_rquery();
        t_bad();
        t_rset();
        t_local();
        t_tx();
        final_report(1'b0);
    end
endmodule // testbench
